// ==== core/clk_rst_boot_pkg.sv ====
// Shared constants and types for clock, reset and boot control
package clk_rst_boot_pkg;
  localparam int unsigned SYS_CLK_HZ = 40_000_000;
  localparam int unsigned MSEL_W = 7;
  localparam int unsigned RATIO_COUNT = 128;
  localparam int unsigned LOCK_CYCLES = 512;
  localparam int unsigned LOCK_CNT_W = 10;
  localparam logic [9:0] LOCK_CNT_LAST = 10'h1ff;
  localparam logic [23:0] BOOT_ROM_ADDR = 24'hff0000;
  localparam logic [6:0] MSEL_RESET = 7'h00;
  localparam logic DIVIDE_RESET = 1'b0;
  localparam logic RATIO_RESET = 1'b0;
  localparam logic [2:0] BOOT_STRAP_RESET = 3'h0;
  localparam int unsigned POR_STRETCH_CYCLES = 16;
  localparam logic [4:0] POR_CNT_LAST = 5'h0f;

  typedef enum logic [2:0] {
    BOOT_ILLEGAL0 = 3'b000,
    BOOT_EXT8_LOAD = 3'b001,
    BOOT_EXT8_EXEC = 3'b010,
    BOOT_EXT16_EXEC = 3'b011,
    BOOT_SPI_SMALL = 3'b100,
    BOOT_SPI_LARGE = 3'b101,
    BOOT_ILLEGAL6 = 3'b110,
    BOOT_ILLEGAL7 = 3'b111
  } boot_mode_t;

  typedef struct packed {
    logic [6:0] multiplier_select;
    logic input_divide_flag;
    logic peripheral_ratio_select;
  } pll_cfg_t;

  typedef struct packed {
    logic boot_irq;
    logic [23:0] boot_vector;
    boot_mode_t mode;
    logic mode_valid;
  } boot_info_t;
endpackage

// ==== core/sync_2ff.sv ====
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
`default_nettype none
module sync_2ff #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Data
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Meta stage feeds only the second stage
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule
`default_nettype wire

// ==== core/periph_clk_gen.sv ====
// Peripheral clock generator: core rate or half core rate
`timescale 1ns/100ps
`default_nettype none
module periph_clk_gen
  import clk_rst_boot_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Ratio select
  input wire logic i_half_rate,
  // Peripheral clock enable pulse and level
  output logic o_periph_en,
  output logic o_periph_lvl
);
  logic phase_q;
  logic phase_d;
  logic lvl_q;
  logic lvl_d;

  // Phase toggles each core cycle; full rate enables every cycle
  // Half rate flips the pin only on enabled cycles, so it runs at half the full-rate toggle
  always_comb
  begin
    phase_d = ~phase_q;
    lvl_d = i_half_rate ? (phase_q ? ~lvl_q : lvl_q) : ~lvl_q;
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      phase_q <= 1'b0;
      lvl_q <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      lvl_q <= lvl_d;
    end
  end

  assign o_periph_en = i_half_rate ? phase_q : 1'b1;
  assign o_periph_lvl = lvl_q;
endmodule
`default_nettype wire

// ==== core/clock_reset_boot_control.sv ====
// Clock ratio, reset sequencing and boot mode control
// Contract
// - Multiplier offers 128 ratio codes spanning one to thirty-two times.
// - Reset-time factor comes from bypass strap, multiplier select and divide flag.
// - Software may change the factor at run time without reset.
// - Peripheral clock is core clock or half, chosen by ratio select.
// - Clock output pin carries the peripheral clock.
// - Low reset input fully resets the device.
// - Power-on reset output asserts at power-up and on low supply.
// - Master reset empties stacks, masks interrupts, restores register defaults.
// - Reset release without bus request jumps to boot ROM at 0xFF0000.
// - Boot interrupt is nonmaskable, vectoring to start of boot ROM.
// - Boot interrupt follows hardware reset or software reset write.
// - Execution always starts in boot ROM regardless of strap pins.
// - Boot straps are sampled at hardware reset only.
// - Strap codes 1 to 5 select the five documented boot modes.
`timescale 1ns/100ps
`default_nettype none
module clock_reset_boot_control
  import clk_rst_boot_pkg::*;
#(
  parameter int unsigned MUL_W = MSEL_W
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Board pins
  input wire logic i_reset_n,
  input wire logic i_bypass,
  input wire logic i_boot_select_bit2,
  input wire logic i_boot_select_bit1,
  input wire logic i_boot_select_bit0,
  input wire logic i_supply_low,
  input wire logic i_bus_request,
  // Software control
  input wire logic i_cfg_write,
  input wire pll_cfg_t i_cfg_wdata,
  input wire logic i_soft_reset,
  // PLL and clock outputs
  output pll_cfg_t o_pll_cfg,
  output logic o_pll_bypass,
  output logic o_pll_locked,
  output logic o_periph_clk_en,
  output logic o_clock_output_pin,
  // Reset outputs
  output logic o_por_n,
  output logic o_core_rst,
  output logic o_stack_clear,
  output logic o_irq_mask_all,
  // Boot outputs
  output boot_info_t o_boot,
  output logic o_boot_jump
);
  logic reset_n_s;
  logic bypass_s;
  logic [2:0] straps_s;
  logic supply_low_s;
  logic bus_req_s;

  // Synchronise every pin before use
  sync_2ff #(.W(5), .RST_VAL(5'h10)) u_sync_pins (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_reset_n, i_bypass, i_boot_select_bit2, i_boot_select_bit1,
      i_boot_select_bit0}),
    .o_sync({reset_n_s, bypass_s, straps_s})
  );

  sync_2ff #(.W(2), .RST_VAL(2'h0)) u_sync_misc (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_supply_low, i_bus_request}),
    .o_sync({supply_low_s, bus_req_s})
  );

  // Reset sequencer states
  typedef enum logic [1:0] {
    ST_HELD = 2'b00,
    ST_LOCK = 2'b01,
    ST_BOOT = 2'b10,
    ST_RUN = 2'b11
  } seq_state_t;

  seq_state_t state_q;
  seq_state_t state_d;
  logic [LOCK_CNT_W-1:0] lock_cnt_q;
  logic [LOCK_CNT_W-1:0] lock_cnt_d;
  logic [4:0] por_cnt_q;
  logic [4:0] por_cnt_d;
  logic por_n_q;
  logic por_n_d;
  pll_cfg_t cfg_q;
  pll_cfg_t cfg_d;
  logic bypass_q;
  logic bypass_d;
  logic [2:0] strap_q;
  logic [2:0] strap_d;
  logic irq_q;
  logic irq_d;
  logic jump_q;
  logic jump_d;
  logic hw_reset;

  // Any low on the reset pin is a full hardware reset
  // full hardware reset
  assign hw_reset = ~reset_n_s;

  // Power-on reset output: held from power-up, stretched after supply dips
  // power-on reset output
  always_comb
  begin
    por_cnt_d = por_cnt_q;
    por_n_d = por_n_q;
    if (supply_low_s)
    begin
      por_cnt_d = 5'h00;
      por_n_d = 1'b0;
    end
    else if (!por_n_q)
    begin
      if (por_cnt_q == POR_CNT_LAST)
        por_n_d = 1'b1;
      else
        por_cnt_d = por_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      por_cnt_q <= 5'h00;
      por_n_q <= 1'b0;
    end
    else
    begin
      por_cnt_q <= por_cnt_d;
      por_n_q <= por_n_d;
    end
  end

  // Sequencer: hold, lock wait, boot entry, run
  always_comb
  begin
    state_d = state_q;
    lock_cnt_d = lock_cnt_q;
    irq_d = 1'b0;
    jump_d = 1'b0;
    if (hw_reset)
    begin
      state_d = ST_HELD;
      lock_cnt_d = '0;
    end
    else
    begin
      unique case (state_q)
        ST_HELD:
        begin
          state_d = ST_LOCK;
          lock_cnt_d = '0;
        end
        ST_LOCK:
        begin
          if (lock_cnt_q == LOCK_CNT_LAST)
            state_d = ST_BOOT;
          else
            lock_cnt_d = lock_cnt_q + 1'b1;
        end
        ST_BOOT:
        begin
          if (!bus_req_s)
          begin
            irq_d = 1'b1;
            jump_d = 1'b1;
            state_d = ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (i_soft_reset)
            state_d = ST_BOOT;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_q <= ST_HELD;
      lock_cnt_q <= '0;
      irq_q <= 1'b0;
      jump_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      lock_cnt_q <= lock_cnt_d;
      irq_q <= irq_d;
      jump_q <= jump_d;
    end
  end

  // PLL configuration, strap capture
  always_comb
  begin
    cfg_d = cfg_q;
    bypass_d = bypass_q;
    strap_d = strap_q;
    if (hw_reset)
    begin
      cfg_d.multiplier_select = MSEL_RESET;
      cfg_d.input_divide_flag = DIVIDE_RESET;
      cfg_d.peripheral_ratio_select = RATIO_RESET;
      bypass_d = bypass_s;
      strap_d = straps_s;
    end
    else if (i_cfg_write)
      cfg_d = i_cfg_wdata;
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      cfg_q <= '{multiplier_select: MSEL_RESET, input_divide_flag: DIVIDE_RESET,
        peripheral_ratio_select: RATIO_RESET};
      bypass_q <= 1'b0;
      strap_q <= BOOT_STRAP_RESET;
    end
    else
    begin
      cfg_q <= cfg_d;
      bypass_q <= bypass_d;
      strap_q <= strap_d;
    end
  end

  // Peripheral clock: core rate or half
  // ratio select picks divider
  periph_clk_gen u_periph (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_half_rate(cfg_q.peripheral_ratio_select),
    .o_periph_en(o_periph_clk_en),
    .o_periph_lvl(o_clock_output_pin)
  );

  assign o_pll_cfg = cfg_q;
  assign o_pll_bypass = bypass_q;
  assign o_pll_locked = (state_q == ST_BOOT) || (state_q == ST_RUN);

  // stacks empty and interrupts masked in reset
  assign o_core_rst = (state_q == ST_HELD) || (state_q == ST_LOCK);
  assign o_stack_clear = o_core_rst;
  assign o_irq_mask_all = o_core_rst;
  assign o_por_n = por_n_q;

  // nonmaskable boot interrupt to ROM start
  assign o_boot.boot_irq = irq_q;
  assign o_boot.boot_vector = BOOT_ROM_ADDR;
  assign o_boot.mode = boot_mode_t'(strap_q);
  assign o_boot.mode_valid = (strap_q != BOOT_ILLEGAL0) && (strap_q != BOOT_ILLEGAL6)
    && (strap_q != BOOT_ILLEGAL7);
  assign o_boot_jump = jump_q;

  a_lock_interval: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (state_q == ST_LOCK && lock_cnt_q == '0 && !hw_reset) |->
    o_core_rst [*8])
    else $error("core reset released too early");

  // boot jump waits until bus request is released
  a_boot_bus: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    o_boot_jump |-> !$past(bus_req_s))
    else $error("boot jump taken during bus request");

  // vector is boot ROM start, taken only out of reset
  a_boot_vector: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    o_boot.boot_irq |-> (o_boot.boot_vector == 24'hff0000 && o_boot_jump && o_pll_locked
    && !o_core_rst))
    else $error("boot interrupt without ROM vector");

  // reset pin low forces core reset
  a_hw_reset: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    hw_reset |=> o_core_rst && o_irq_mask_all && o_stack_clear)
    else $error("reset pin did not reset core");

  a_cfg_write: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_cfg_write && !hw_reset) |=> o_pll_cfg == $past(i_cfg_wdata))
    else $error("configuration write lost");

  a_strap_hold: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    !$past(hw_reset) |-> $stable(o_boot.mode))
    else $error("boot mode changed outside reset");

  a_por_dip: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    supply_low_s |=> !o_por_n [*2])
    else $error("power-on reset not asserted on supply dip");

  // software reset leads to boot interrupt
  a_soft_boot: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (state_q == ST_RUN && i_soft_reset && !hw_reset && !bus_req_s) |=>
    ##1 o_boot.boot_irq)
    else $error("software reset gave no boot interrupt");
endmodule
`default_nettype wire

// ==== bench/board_reset_src.sv ====
// Board reset source that stretches its reset pin
`timescale 1ns/100ps
`default_nettype none
module board_reset_src #(
  parameter int unsigned HOLD = 512
) (
  // Clock and request
  input wire logic i_sys_clk,
  input wire logic i_hold,
  // Reset pin
  output logic o_reset_n
);
  int unsigned cnt_q = 0;
  always @(posedge i_sys_clk)
  begin
    if (i_hold)
      cnt_q <= HOLD;
    else if (cnt_q != 0)
      cnt_q <= cnt_q - 1;
  end
  // Pin stays low while requested and while the stretch runs
  assign o_reset_n = !i_hold && (cnt_q == 0);
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// Testbench for clock, reset and boot control
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import clk_rst_boot_pkg::*;
  logic i_sys_clk, i_sys_rst, i_bypass, i_supply_low, i_bus_request, i_cfg_write, i_soft_reset;
  logic hold_req, reset_n, o_pll_bypass, o_pll_locked, o_periph_clk_en, o_clock_output_pin;
  logic o_por_n, o_core_rst, o_stack_clear, o_irq_mask_all, o_boot_jump;
  logic [2:0] strap;
  pll_cfg_t i_cfg_wdata, o_pll_cfg;
  boot_info_t o_boot;
  int fail_count = 0;
  int checks_done = 0;
  int ef, tf, eh, th, n;

  board_reset_src #(.HOLD(LOCK_CYCLES)) board (.i_sys_clk(i_sys_clk), .i_hold(hold_req),
    .o_reset_n(reset_n));
  clock_reset_boot_control dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_reset_n(reset_n), .i_bypass(i_bypass), .i_boot_select_bit2(strap[2]),
    .i_boot_select_bit1(strap[1]), .i_boot_select_bit0(strap[0]),
    .i_supply_low(i_supply_low), .i_bus_request(i_bus_request), .i_cfg_write(i_cfg_write),
    .i_cfg_wdata(i_cfg_wdata), .i_soft_reset(i_soft_reset), .o_pll_cfg(o_pll_cfg),
    .o_pll_bypass(o_pll_bypass), .o_pll_locked(o_pll_locked),
    .o_periph_clk_en(o_periph_clk_en), .o_clock_output_pin(o_clock_output_pin),
    .o_por_n(o_por_n), .o_core_rst(o_core_rst), .o_stack_clear(o_stack_clear),
    .o_irq_mask_all(o_irq_mask_all), .o_boot(o_boot), .o_boot_jump(o_boot_jump));

  initial
  begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  // Compare one value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge i_sys_clk);
  endtask

  // Count cycles until the boot jump pulse, giving up at lim
  task automatic wait_jump(input int lim, output int k);
    k = 0;
    while (o_boot_jump !== 1'b1 && k < lim)
    begin
      tick(1);
      k++;
    end
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Pin reset with given straps, then boot timing and capture
  task automatic t_boot(input logic [2:0] code, input logic breq);
    int k;
    @(posedge i_sys_clk);
    strap <= code;
    i_bypass <= code[0];
    i_bus_request <= breq;
    hold_req <= 1'b1;
    tick(6);
    chk(o_core_rst, 1, "core reset");
    chk(o_stack_clear & o_irq_mask_all, 1, "stack and mask");
    @(posedge i_sys_clk);
    hold_req <= 1'b0;
    wait (reset_n === 1'b1);
    tick(6);
    @(posedge i_sys_clk);
    strap <= ~code;
    i_bypass <= ~code[0];
    wait_jump(700, k);
    if (breq)
    begin
      chk(k, 700, "boot while bus held");
      @(posedge i_sys_clk);
      i_bus_request <= 1'b0;
      wait_jump(20, k);
    end
    else
      chk(k >= LOCK_CYCLES - 12 && k <= LOCK_CYCLES + 4, 1, "lock interval");
    chk(o_boot.boot_irq, 1, "boot irq");
    chk(o_boot.boot_vector, BOOT_ROM_ADDR, "boot vector");
    chk(o_boot.mode, code, "boot mode");
    chk(o_boot.mode_valid, code inside {[3'h1:3'h5]}, "mode valid");
    chk(o_pll_bypass, code[0], "bypass capture");
    chk(o_pll_locked & ~o_core_rst, 1, "locked");
  endtask

  // Back to back config writes
  task automatic t_cfg;
    chk(o_pll_cfg, 9'h000, "cfg default");
    // divide flag kept clear for the 40 MHz input
    @(posedge i_sys_clk);
    i_cfg_write <= 1'b1;
    i_cfg_wdata <= 9'h1a5;
    @(posedge i_sys_clk);
    i_cfg_wdata <= 9'h058;
    @(negedge i_sys_clk);
    chk(o_pll_cfg, 9'h1a5, "cfg first");
    @(posedge i_sys_clk);
    i_cfg_write <= 1'b0;
    @(negedge i_sys_clk);
    chk(o_pll_cfg, 9'h058, "cfg second");
  endtask

  // Peripheral enable and output pin activity at one ratio
  task automatic t_periph(input logic half, output int en, output int tg);
    logic last;
    // low ratio code, divide flag clear
    @(posedge i_sys_clk);
    i_cfg_write <= 1'b1;
    i_cfg_wdata <= {7'h03, 1'b0, half};
    @(posedge i_sys_clk);
    i_cfg_write <= 1'b0;
    tick(4);
    en = 0;
    tg = 0;
    last = o_clock_output_pin;
    repeat (16)
    begin
      tick(1);
      en += (o_periph_clk_en === 1'b1);
      tg += (o_clock_output_pin !== last);
      last = o_clock_output_pin;
    end
  endtask

  initial
  begin
    i_sys_rst = 1'b1;
    hold_req = 1'b1;
    strap = 3'h1;
    {i_bypass, i_supply_low, i_bus_request, i_cfg_write, i_soft_reset} = '0;
    i_cfg_wdata = '0;
    tick(2);
    chk(o_por_n, 0, "por in reset");
    repeat (6) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    tick(2);
    // codes 0, 6 and 7 driven on purpose to see them flagged
    for (int c = 0; c < 8; c++)
      t_boot(c[2:0], c == 2);
    // Config writes only land once the reset pin is released
    t_cfg();
    t_periph(1'b0, ef, tf);
    t_periph(1'b1, eh, th);
    chk(ef, 16, "full rate enable");
    chk(eh, 8, "half rate enable");
    chk(tf == 2 * th && th != 0, 1, "pin follows peripheral clock");
    @(posedge i_sys_clk);
    i_soft_reset <= 1'b1;
    @(posedge i_sys_clk);
    i_soft_reset <= 1'b0;
    wait_jump(6, n);
    chk(n < 6, 1, "soft reset boot");
    chk(o_boot.mode, 3'h7, "straps kept");
    @(posedge i_sys_clk);
    i_supply_low <= 1'b1;
    tick(6);
    chk(o_por_n, 0, "por on low supply");
    @(posedge i_sys_clk);
    i_supply_low <= 1'b0;
    n = 0;
    while (o_por_n !== 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    chk(n < 40, 1, "por release");
    summarize();
  end

  // Watchdog for a hung run
  initial
  begin
    #1ms;
    fail_count++;
    summarize();
  end
endmodule
`default_nettype wire
